// ### logic/swf_target.sv
`timescale 1ns/100ps
module swf_target (
  input wire logic clk,
  input wire logic srst,
  input wire logic swclk,
  input wire logic swdioIn,
  output logic swdioOut,
  output logic swdioOe,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  typedef enum logic [2:0] {
    IDLE,
    REQ,
    TRN_IN,
    ACK,
    RDATA,
    TRN_OUT,
    WDATA
  } swf_state_t;

  swf_state_t state_q;
  logic swclkRise;
  logic swdioSync;
  logic lineResetHit;
  logic [5:0] bitCnt_q;
  logic [1:0] trnCnt_q;
  logic [6:0] reqSr_q;
  logic [6:0] reqNext;
  swf_pkg::swf_req_t reqFields;
  swf_pkg::swf_req_t curReq_q;
  logic [2:0] ack_q;
  logic [2:0] ackSel;
  logic [31:0] shift_q;
  logic toWrite_q;
  logic hasData;
  logic trnDone;
  logic reqErrEv_q;
  logic parErrEv_q;
  logic wrDoneEv_q;
  logic rdDoneEv_q;
  logic [4:0] ctrl_q;
  logic [1:0] trnField;
  logic [4:0] status_q;
  logic [4:0] statusSet;
  logic [4:0] statusClr;
  logic [31:0] readData_q;
  logic [31:0] writeData_q;
  logic [10:0] lastReq_q;
  logic [3:0] apBank_q;
  swf_pkg::swf_bus_phase_t dp_q;
  logic addrTaken;
  logic [31:0] rdMux;

  swf_sync u_sync (
    .clk(clk),
    .srst(srst),
    .swclkPin(swclk),
    .swdioPin(swdioIn),
    .swdioSample(swdioSync),
    .swclkRise(swclkRise)
  );

  swf_line_reset u_line_reset (
    .clk(clk),
    .srst(srst),
    .bitStrobe(swclkRise),
    .bitValue(swdioSync),
    .lineReset(lineResetHit)
  );

  assign trnField = ctrl_q[swf_pkg::CTRL_TRN_MSB:swf_pkg::CTRL_TRN_LSB];
  assign trnDone = (trnCnt_q == trnField);
  assign reqNext = {swdioSync, reqSr_q[6:1]};
  assign reqFields = swf_pkg::swf_req_t'(reqNext[3:0]);
  assign hasData = (ack_q == swf_pkg::ACK_OK) || ctrl_q[swf_pkg::CTRL_OVERRUN_DETECT];

  assign ackSel = ctrl_q[swf_pkg::CTRL_FAULT] ? swf_pkg::ACK_FAULT :
    (ctrl_q[swf_pkg::CTRL_NOT_READY] ? swf_pkg::ACK_WAIT : swf_pkg::ACK_OK);

  // Link engine; host drives on falling edges, so sample and launch on rising
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= IDLE;
      bitCnt_q <= 6'h00;
      trnCnt_q <= 2'h0;
      reqSr_q <= 7'h00;
      curReq_q <= '0;
      ack_q <= swf_pkg::ACK_OK;
      shift_q <= swf_pkg::DATA_RESET;
      toWrite_q <= 1'b0;
      swdioOut <= 1'b0;
      swdioOe <= 1'b0;
      writeData_q <= swf_pkg::DATA_RESET;
      reqErrEv_q <= 1'b0;
      parErrEv_q <= 1'b0;
      wrDoneEv_q <= 1'b0;
      rdDoneEv_q <= 1'b0;
    end
    else
    begin
      reqErrEv_q <= 1'b0;
      parErrEv_q <= 1'b0;
      wrDoneEv_q <= 1'b0;
      rdDoneEv_q <= 1'b0;
      if (lineResetHit)
      begin
        state_q <= IDLE;
        swdioOe <= 1'b0;
        swdioOut <= 1'b0;
      end
      else if (swclkRise)
      begin
        unique case (state_q)
          IDLE:
          begin
            bitCnt_q <= 6'h00;
            if (swdioSync)
            begin
              state_q <= REQ;
            end
          end
          REQ:
          begin
            reqSr_q <= reqNext;
            bitCnt_q <= bitCnt_q + 6'h01;
            if (bitCnt_q == swf_pkg::REQ_LAST_BIT)
            begin
              trnCnt_q <= 2'h0;
              bitCnt_q <= 6'h00;
              // Parity, stop and park all checked; no answer if any is wrong
              if ((reqNext[4] != ^reqNext[3:0]) || reqNext[5] || !reqNext[6])
              begin
                state_q <= IDLE;
                reqErrEv_q <= 1'b1;
              end
              else
              begin
                state_q <= TRN_IN;
                curReq_q <= reqFields;
                ack_q <= ackSel;
              end
            end
          end
          TRN_IN:
          begin
            if (trnDone)
            begin
              state_q <= ACK;
              swdioOe <= 1'b1;
              swdioOut <= ack_q[0];
              bitCnt_q <= 6'h01;
            end
            else
            begin
              trnCnt_q <= trnCnt_q + 2'h1;
            end
          end
          ACK:
          begin
            if (bitCnt_q < swf_pkg::ACK_BITS)
            begin
              swdioOut <= ack_q[bitCnt_q[1:0]];
              bitCnt_q <= bitCnt_q + 6'h01;
            end
            else if (hasData && curReq_q.readNotWrite)
            begin
              state_q <= RDATA;
              swdioOut <= readData_q[0];
              shift_q <= readData_q;
              bitCnt_q <= 6'h01;
            end
            else
            begin
              swdioOe <= 1'b0;
              swdioOut <= 1'b0;
              bitCnt_q <= 6'h00;
              trnCnt_q <= 2'h0;
              toWrite_q <= hasData;
              // Full turnaround before the host may drive again
              state_q <= TRN_OUT;
            end
          end
          RDATA:
          begin
            bitCnt_q <= bitCnt_q + 6'h01;
            if (bitCnt_q < swf_pkg::DATA_BITS)
            begin
              swdioOut <= shift_q[bitCnt_q[4:0]];
            end
            else if (bitCnt_q == swf_pkg::DATA_BITS)
            begin
              swdioOut <= swf_pkg::evenParity(shift_q);
            end
            else
            begin
              swdioOe <= 1'b0;
              swdioOut <= 1'b0;
              rdDoneEv_q <= 1'b1;
              trnCnt_q <= 2'h0;
              toWrite_q <= 1'b0;
              state_q <= TRN_OUT;
            end
          end
          TRN_OUT:
          begin
            bitCnt_q <= 6'h00;
            if (trnDone)
            begin
              state_q <= toWrite_q ? WDATA : IDLE;
            end
            else
            begin
              trnCnt_q <= trnCnt_q + 2'h1;
            end
          end
          WDATA:
          begin
            bitCnt_q <= bitCnt_q + 6'h01;
            if (bitCnt_q < swf_pkg::DATA_BITS)
            begin
              shift_q <= {swdioSync, shift_q[31:1]};
            end
            else
            begin
              // Committed on the parity edge, so no trailing clocks needed
              state_q <= IDLE;
              if (swdioSync != swf_pkg::evenParity(shift_q))
              begin
                parErrEv_q <= 1'b1;
              end
              else if (ack_q == swf_pkg::ACK_OK)
              begin
                writeData_q <= shift_q;
                wrDoneEv_q <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // Resolved register: debug port by address alone, access port adds bank
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      lastReq_q <= 11'h000;
    end
    else if (state_q == TRN_IN && swclkRise && trnDone && !lineResetHit)
    begin
      lastReq_q <= {ack_q, curReq_q.portSelect ? apBank_q : 4'h0, curReq_q};
    end
  end

  // Sticky status; a set in the clearing cycle wins
  assign statusSet = {rdDoneEv_q, wrDoneEv_q, lineResetHit, parErrEv_q, reqErrEv_q};
  assign statusClr = (dp_q.valid && dp_q.write && dp_q.offset == swf_pkg::OFS_STATUS) ?
    hwdata[swf_pkg::STAT_STICKY_BITS-1:0] : 5'h00;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      status_q <= 5'h00;
    end
    else
    begin
      status_q <= (status_q & ~statusClr) | statusSet;
    end
  end

  // Bus slave, zero wait states
  assign addrTaken = hsel && hready && htrans[1];

  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (haddr[7:0])
      swf_pkg::OFS_CTRL: rdMux = {27'h000_0000, ctrl_q};
      swf_pkg::OFS_STATUS: rdMux = {23'h00_0000, state_q != IDLE, 3'h0, status_q};
      swf_pkg::OFS_READ_DATA: rdMux = readData_q;
      swf_pkg::OFS_WRITE_DATA: rdMux = writeData_q;
      swf_pkg::OFS_LAST_REQ: rdMux = {21'h00_0000, lastReq_q};
      swf_pkg::OFS_AP_SELECT: rdMux = {28'h000_0000, apBank_q};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dp_q <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready)
      begin
        dp_q <= '{addrTaken, hwrite, swf_pkg::isMapped(haddr), haddr[7:0]};
        hrdata <= (addrTaken && !hwrite && swf_pkg::isMapped(haddr)) ? rdMux : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_q <= swf_pkg::CTRL_RESET;
      readData_q <= swf_pkg::DATA_RESET;
      apBank_q <= swf_pkg::AP_BANK_RESET;
    end
    else if (dp_q.valid && dp_q.write && dp_q.mapped)
    begin
      if (dp_q.offset == swf_pkg::OFS_CTRL)
        ctrl_q <= hwdata[4:0];
      if (dp_q.offset == swf_pkg::OFS_READ_DATA)
        readData_q <= hwdata;
      if (dp_q.offset == swf_pkg::OFS_AP_SELECT)
        apBank_q <= hwdata[3:0];
    end
  end
endmodule

// ### logic/swf_pkg.sv
package swf_pkg;

  // Serial framing
  localparam logic [5:0] REQ_LAST_BIT = 6'h06;
  localparam logic [5:0] ACK_BITS = 6'h03;
  localparam logic [5:0] DATA_BITS = 6'h20;
  localparam logic [5:0] LINE_RESET_ONES = 6'h32;

  // Acknowledge codes, sent LSB first
  localparam logic [2:0] ACK_OK = 3'h1;
  localparam logic [2:0] ACK_WAIT = 3'h2;
  localparam logic [2:0] ACK_FAULT = 3'h4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_READ_DATA = 8'h08;
  localparam logic [7:0] OFS_WRITE_DATA = 8'h0c;
  localparam logic [7:0] OFS_LAST_REQ = 8'h10;
  localparam logic [7:0] OFS_AP_SELECT = 8'h14;

  // Control field positions
  localparam int CTRL_OVERRUN_DETECT = 0;
  localparam int CTRL_FAULT = 1;
  localparam int CTRL_NOT_READY = 2;
  localparam int CTRL_TRN_LSB = 3;
  localparam int CTRL_TRN_MSB = 4;

  // Status field positions, all write-one-to-clear except busy
  localparam int STAT_REQ_ERROR = 0;
  localparam int STAT_WR_PARITY = 1;
  localparam int STAT_LINE_RESET = 2;
  localparam int STAT_WRITE_DONE = 3;
  localparam int STAT_READ_DONE = 4;
  localparam int STAT_STICKY_BITS = 5;
  localparam int STAT_BUSY = 8;

  // Reset values
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [3:0] AP_BANK_RESET = 4'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [1:0] addr;
    logic readNotWrite;
    logic portSelect;
  } swf_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic mapped;
    logic [7:0] offset;
  } swf_bus_phase_t;

  function automatic logic evenParity(input logic [31:0] data);
    return ^data;
  endfunction

  function automatic logic isMapped(input logic [31:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr[31:8] == 24'h00_0000)
    begin
      hit = (addr[7:0] == OFS_CTRL) || (addr[7:0] == OFS_STATUS) ||
        (addr[7:0] == OFS_READ_DATA) || (addr[7:0] == OFS_WRITE_DATA) ||
        (addr[7:0] == OFS_LAST_REQ) || (addr[7:0] == OFS_AP_SELECT);
    end
    return hit;
  endfunction

endpackage

// ### logic/swf_sync.sv
`timescale 1ns/100ps
module swf_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic swclkPin,
  input wire logic swdioPin,
  output logic swdioSample,
  output logic swclkRise
);
  logic [1:0] meta_q;
  logic [1:0] stable_q;
  logic clkDelay_q;

  // Stage one only feeds stage two; edge found on the stable copy
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_q <= 2'h0;
      stable_q <= 2'h0;
      clkDelay_q <= 1'b0;
    end
    else
    begin
      meta_q <= {swdioPin, swclkPin};
      stable_q <= meta_q;
      clkDelay_q <= stable_q[0];
    end
  end

  assign swclkRise = stable_q[0] & ~clkDelay_q;
  assign swdioSample = stable_q[1];
endmodule

// ### logic/swf_line_reset.sv
`timescale 1ns/100ps
module swf_line_reset (
  input wire logic clk,
  input wire logic srst,
  input wire logic bitStrobe,
  input wire logic bitValue,
  output logic lineReset
);
  logic [5:0] ones_q;

  // Saturates so a long run of ones gives one reset pulse only
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ones_q <= 6'h00;
      lineReset <= 1'b0;
    end
    else
    begin
      lineReset <= 1'b0;
      if (bitStrobe)
      begin
        if (!bitValue)
        begin
          ones_q <= 6'h00;
        end
        else if (ones_q != swf_pkg::LINE_RESET_ONES)
        begin
          ones_q <= ones_q + 6'h01;
          lineReset <= (ones_q == swf_pkg::LINE_RESET_ONES - 6'h01);
        end
      end
    end
  end
endmodule

// ### testbench/swf_target_monitor.sv
`timescale 1ns/100ps
module swf_target_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic swclk,
  input wire logic swdioOut,
  input wire logic swdioOe,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp
);
  logic pinClk_q;
  logic [3:0] sinceRise_q;
  logic [8:0] oeRun_q;
  logic rdTaken;
  assign rdTaken = hsel && hready && htrans[1] && !hwrite;
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // Raw pin edge; the design sees it a few cycles later through its synchroniser
  always_ff @(posedge clk)
  begin
    pinClk_q <= swclk;
    if (srst)
      sinceRise_q <= 4'hf;
    else if (swclk && !pinClk_q)
      sinceRise_q <= 4'h0;
    else if (sinceRise_q != 4'hf)
      sinceRise_q <= sinceRise_q + 4'h1;
  end
  always_ff @(posedge clk)
  begin
    oeRun_q <= swdioOe ? oeRun_q + 9'h001 : 9'h000;
  end
  reset_values_a: assert property ($fell(srst) |-> !swdioOe && hrdata == 32'h0)
    else $error("outputs not cleared by reset");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or error response");
  idle_rdata_a: assert property (!rdTaken |=> hrdata == 32'h0)
    else $error("read data outside a read phase");
  unmapped_read_a: assert property (rdTaken && haddr > 32'h14 |=> hrdata == 32'h0)
    else $error("unmapped read returned data");
  oe_edge_a: assert property ($changed(swdioOe) |-> sinceRise_q < 4'h8)
    else $error("drive enable moved away from a clock rise");
  out_edge_a: assert property (swdioOe && $changed(swdioOut) |-> sinceRise_q < 4'h8)
    else $error("driven bit moved away from a clock rise");
  ack_hold_a: assert property ($rose(swdioOe) |-> swdioOe [*8])
    else $error("acknowledge drive too short");
  drive_max_a: assert property (oeRun_q < 9'h190)
    else $error("target drove the line too long");
  cover property ($rose(swdioOe));
  cover property (rdTaken);
  cover property (oeRun_q > 9'h12c);
endmodule

bind swf_target swf_target_monitor u_swf_target_monitor (.clk(clk), .srst(srst),
  .swclk(swclk), .swdioOut(swdioOut), .swdioOe(swdioOe), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp));

// ### testbench/swf_host_model.sv
`timescale 1ns/100ps
module swf_host_model (
  input wire logic swdio,
  output logic swclk,
  output logic hostOut,
  output logic hostOe
);
  initial
  begin
    swclk = 1'b0;
    hostOut = 1'b0;
    hostOe = 1'b0;
  end
  // Data moves mid-period so it never races the target's sampling rise
  task automatic bitc(input logic oe, input logic v, output logic s);
    hostOe = oe;
    hostOut = v;
    #24;
    s = swdio;
    swclk = 1'b1;
    #24;
    swclk = 1'b0;
  endtask
  task automatic op(input logic [7:0] q, input int trn, input logic dat, input logic [32:0] wd,
    output logic [2:0] ack, output logic [32:0] rd);
    logic s;
    #1.3;
    for (int i = 0; i < 8; i++)
      bitc(i != 7, q[i], s);
    repeat (trn) bitc(1'b0, 1'b0, s);
    for (int i = 0; i < 3; i++)
    begin
      bitc(1'b0, 1'b0, s);
      ack[i] = s;
    end
    // Line left undriven on every change of direction
    if (!(dat && q[2]))
      repeat (trn) bitc(1'b0, 1'b0, s);
    for (int i = 0; i < 33 && dat; i++)
    begin
      bitc(!q[2], wd[i], s);
      rd[i] = s;
    end
    if (dat && q[2])
      repeat (trn) bitc(1'b0, 1'b0, s);
    repeat (8) bitc(1'b1, 1'b0, s);
    hostOe = 1'b0;
  endtask
  task automatic lineReset;
    logic s;
    #1.3;
    repeat (52) bitc(1'b1, 1'b1, s);
    repeat (8) bitc(1'b1, 1'b0, s);
    hostOe = 1'b0;
  endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, swdioOut, swdioOe, swclk, hostOut, hostOe;
  logic [31:0] hrdata;
  logic [2:0] ack;
  logic [32:0] rd;
  wire swdio;
  int error_cnt = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  // Pull-up wins when nobody drives
  assign swdio = swdioOe ? swdioOut : (hostOe ? hostOut : 1'b1);
  swf_target u_swf_target (.clk(clk), .srst(srst), .swclk(swclk), .swdioIn(swdio),
    .swdioOut(swdioOut), .swdioOe(swdioOe), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  swf_host_model u_swf_host_model (.swdio(swdio), .swclk(swclk), .hostOut(hostOut),
    .hostOe(hostOe));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] r);
    int n;
    hsel <= 1'b1;
    htrans <= swf_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    for (int p = 0; p < 2; p++)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50)
      begin
        error_cnt++;
        end_sim();
      end
      if (p == 0)
      begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
      end
    end
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check({1'b0, r}, {1'b0, exp});
  endtask
  function automatic logic [7:0] rq(input logic ap, input logic read_not_write_bit, input logic [1:0] a,
    input logic bad);
    return {2'h2, ap ^ read_not_write_bit ^ a[0] ^ a[1] ^ bad, a[1], a[0], read_not_write_bit, ap, 1'b1};
  endfunction
  task automatic xfer(input logic [7:0] q, input int trn, input logic dat, input logic [32:0] w);
    u_swf_host_model.op(q, trn, dat, w, ack, rd);
    repeat (4) @(posedge clk);
  endtask
  task automatic rdOne(input logic [31:0] v, input int trn);
    wr(swf_pkg::OFS_READ_DATA, v);
    xfer(rq(1'b0, 1'b1, 2'h3, 1'b0), trn, 1'b1, 33'h0);
    check({30'h0, ack}, {30'h0, swf_pkg::ACK_OK});
    check(rd, {^v, v});
  endtask
  task automatic t_read;
    rdc(swf_pkg::OFS_CTRL, 32'h0);
    rdOne(32'h8000_0001, 1);
    rdOne(32'h0000_0007, 1);
    rdc(swf_pkg::OFS_LAST_REQ, {21'h0, swf_pkg::ACK_OK, 8'h0e});
    wr(swf_pkg::OFS_CTRL, 32'h10);
    rdOne(32'h5a5a_0f0f, 3);
    wr(swf_pkg::OFS_CTRL, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rdc(8'h40, 32'h0);
    $display("read test done");
  endtask
  task automatic t_write;
    logic [31:0] w;
    w = 32'h1234_5678;
    wr(swf_pkg::OFS_STATUS, 32'h1f);
    wr(swf_pkg::OFS_AP_SELECT, 32'h5);
    xfer(rq(1'b1, 1'b0, 2'h1, 1'b0), 1, 1'b1, {^w, w});
    check({30'h0, ack}, {30'h0, swf_pkg::ACK_OK});
    rdc(swf_pkg::OFS_WRITE_DATA, w);
    rdc(swf_pkg::OFS_LAST_REQ, {21'h0, swf_pkg::ACK_OK, 8'h55});
    xfer(rq(1'b0, 1'b0, 2'h1, 1'b0), 1, 1'b1, {~^w, w});
    rdc(swf_pkg::OFS_WRITE_DATA, w);
    rdc(swf_pkg::OFS_STATUS, 32'h0a);
    $display("write test done");
  endtask
  task automatic t_ack;
    wr(swf_pkg::OFS_CTRL, 32'h2);
    xfer(rq(1'b0, 1'b1, 2'h0, 1'b0), 1, 1'b0, 33'h0);
    check({30'h0, ack}, {30'h0, swf_pkg::ACK_FAULT});
    wr(swf_pkg::OFS_CTRL, 32'h4);
    xfer(rq(1'b0, 1'b1, 2'h0, 1'b0), 1, 1'b0, 33'h0);
    check({30'h0, ack}, {30'h0, swf_pkg::ACK_WAIT});
    wr(swf_pkg::OFS_CTRL, 32'h5);
    xfer(rq(1'b0, 1'b0, 2'h2, 1'b0), 1, 1'b1, {1'b0, 32'h0000_0003});
    check({30'h0, ack}, {30'h0, swf_pkg::ACK_WAIT});
    rdc(swf_pkg::OFS_WRITE_DATA, 32'h1234_5678);
    wr(swf_pkg::OFS_CTRL, 32'h0);
    rdOne(32'h0000_0001, 1);
    $display("ack test done");
  endtask
  task automatic t_bad;
    wr(swf_pkg::OFS_STATUS, 32'h1f);
    xfer(rq(1'b0, 1'b1, 2'h0, 1'b1), 1, 1'b0, 33'h0);
    check({30'h0, ack}, {30'h0, 3'h7});
    xfer(rq(1'b0, 1'b1, 2'h0, 1'b0) ^ 8'h40, 1, 1'b0, 33'h0);
    check({30'h0, ack}, {30'h0, 3'h7});
    rdc(swf_pkg::OFS_STATUS, 32'h1);
    wr(swf_pkg::OFS_STATUS, 32'h1f);
    u_swf_host_model.lineReset();
    repeat (4) @(posedge clk);
    rdc(swf_pkg::OFS_STATUS, 32'h5);
    rdOne(32'hc000_0000, 1);
    $display("error test done");
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_read();
    t_write();
    t_ack();
    t_bad();
    end_sim();
  end
endmodule
